//--- hdl/ufsc_map.svh
// Register map, field positions, reset values and timing counts
`ifndef UFSC_MAP_SVH
`define UFSC_MAP_SVH
`define UFSC_A_ISR      8'h08
`define UFSC_A_TOP_IRQ_ENABLE_REG    8'h04
`define UFSC_A_SPCL     8'h18
`define UFSC_A_STS      8'h20
`define UFSC_A_FIRST_MODE_REG    8'h24
`define UFSC_A_FLOW_THRESHOLD_REG  8'h3c
`define UFSC_A_TRGLVL   8'h40
`define UFSC_A_TXLVL    8'h44
`define UFSC_A_RXLVL    8'h48
`define UFSC_A_FLOW     8'h4c
`define UFSC_A_RESUME_CHAR_FIRST     8'h50
`define UFSC_A_RESUME_CHAR_SECOND     8'h54
`define UFSC_A_PAUSE_CHAR_FIRST    8'h58
`define UFSC_A_PAUSE_CHAR_SECOND    8'h5c
`define UFSC_B_RX_LEVEL_HANDSHAKE_ENABLE  0
`define UFSC_B_TX_GATE_BY_CLEAR_INPUT_ENABLE  1
`define UFSC_B_CLEAR_INPUT_CHANGE_FLAG   7
`define UFSC_B_SPINT    1
`define UFSC_B_RXTRG    3
`define UFSC_B_TXTRG    4
`define UFSC_B_CLKRDY   5
`define UFSC_B_TXOFF    1
`define UFSC_B_FSLEEP   5
`define UFSC_B_ASLEEP   6
`define UFSC_B_IRQSEL   7
`define UFSC_SP_RESUME_CHAR_FIRST    0
`define UFSC_SP_RESUME_CHAR_SECOND    1
`define UFSC_SP_PAUSE_CHAR_FIRST   2
`define UFSC_SP_PAUSE_CHAR_SECOND   3
`define UFSC_DOUBLE     2'h3
`define UFSC_IDLE_CHARS 17'h10000
`define UFSC_CLK_SETTLE 8'h40
`define UFSC_INIT_CYC   8'h10
`endif

//--- hdl/ufsc_pkg.sv
// Types shared by the flow and sleep control block
package ufsc_pkg;
  typedef enum logic [1:0] {
    UFSC_RUN   = 2'b00,
    UFSC_SLEEP = 2'b01,
    UFSC_WAKE  = 2'b10
  } ufsc_pwr_t;
  typedef enum logic [1:0] {
    UFSC_CI_NONE  = 2'b00,
    UFSC_CI_FIRST = 2'b01,
    UFSC_CI_SECOND= 2'b10
  } ufsc_ci_t;
endpackage

//--- hdl/ufsc_thresh.sv
// Hysteresis comparator on a FIFO fill level
`timescale 1ns/1ps
module ufsc_thresh (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  // Level and thresholds
  input  wire logic [7:0] i_level,
  input  wire logic [7:0] i_halt,
  input  wire logic [7:0] i_resume,
  // Stop state
  output logic            o_stop
);
  typedef struct packed {
    logic stop;
  } ufsc_th_t;
  ufsc_th_t s_r;
  ufsc_th_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (i_level > i_halt) begin
      s_nxt.stop = 1'b1;
    end else if (i_level < i_resume) begin
      s_nxt.stop = 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_stop = s_r.stop;
endmodule

//--- hdl/ufsc_top.sv
// Flow control and sleep control of a host programmed UART
// Overview of operation
// - Separate enables for level handshake and clear gating, independent.
// - Handshake output goes high above halt, low again below resume.
// - Crossing halt or resume thresholds raises no interrupt.
// - With gating on, transmit while clear input low, stop while high.
// - A word already shifting finishes before gating halts transmit.
// - Clear change flag keeps working; enable bit 7 routes it.
// - Four registers hold pause and resume characters; double wide mode.
// - Received pause or resume sets flag and records which in detail.
// - Receive flow sends pause above halt, resume below resume level.
// - Double wide sends first byte register then second.
// - Transmit flow: pause halts after current word, resume restarts.
// - Recognised control characters never enter the receive FIFO.
// - Double wide needs first byte match followed by second match.
// - Trigger flags set when FIFO count reaches or exceeds level.
// - Clocks stable flag set after sleep or shutdown exit settles.
// - Manual sleep stops clocks, receiver, transmitter; registers live.
// - Idle sleep needs empty FIFOs, no pending irq, long quiet pins.
// - Idle sleep ends on pin activity or enable bit cleared.
// - Reset pin low holds shutdown; all register contents are lost.
// - Reset rising edge resets, then interrupt output goes high.
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ufsc_map.svh"
module ufsc_top
  import ufsc_pkg::*;
#(
  parameter logic [16:0] IDLE_CHARS = `UFSC_IDLE_CHARS
) (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_rst_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // UART core side
  input  wire logic [7:0]  i_rx_level,
  input  wire logic [7:0]  i_tx_level,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_rx_store,
  input  wire logic        i_tx_word_done,
  input  wire logic        i_tx_busy,
  output logic             o_tx_allow,
  output logic             o_ctl_valid,
  output logic [7:0]       o_ctl_data,
  input  wire logic        i_ctl_ready,
  input  wire logic        i_char_tick,
  input  wire logic        i_other_irq,
  // Pins
  input  wire logic        i_cts_n,
  input  wire logic        i_rxd,
  input  wire logic [3:0]  i_gpi,
  output logic             o_rts_n,
  output logic             o_irq_n,
  output logic             o_sleep
);
  typedef struct packed {
    logic [7:0] top_irq_status_reg;
    logic [7:0] top_irq_enable_reg;
    logic [7:0] spcl;
    logic [7:0] sts;
    logic [7:0] first_mode_reg;
    logic [7:0] flow_threshold_reg;
    logic [7:0] trglvl;
    logic [7:0] flow;
    logic [7:0] resume_char_first;
    logic [7:0] resume_char_second;
    logic [7:0] pause_char_first;
    logic [7:0] pause_char_second;
    logic       ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic       txhalt;
    ufsc_ci_t   ci;
    logic       ci_off;
    logic       cts_q;
    logic       rxd_q;
    logic [3:0] gpi_q;
    logic [16:0] idle;
    ufsc_pwr_t  pwr;
    logic [7:0] settle;
    logic [7:0] init;
    logic       rst_n_q;
    logic       sw_stop;
    logic       gate_q;
  } ufsc_st_t;
  ufsc_st_t s_r;
  ufsc_st_t s_nxt;
  logic       rx_stop;
  logic       seq_req;
  logic       seq_busy;
  logic [7:0] seq_first;
  logic [7:0] seq_second;
  logic       rxfc_on;
  logic       txfc_on;
  logic       rx_dbl;
  logic       tx_dbl;
  logic       m_resume_char_first;
  logic       m_pause_char_first;
  logic       m_resume_char_second;
  logic       m_pause_char_second;
  logic       activity;
  logic       irq_pend;
  logic       is_ctl;
  logic       hit;
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  // Thresholds: low nibble halt, high nibble resume, in units of 8 words
  ufsc_thresh u_rx_thresh (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst | ~i_rst_n),
    .i_level   (i_rx_level),
    .i_halt    ({1'b0, s_r.flow_threshold_reg[3:0], 3'h0}),
    .i_resume  ({1'b0, s_r.flow_threshold_reg[7:4], 3'h0}),
    .o_stop    (rx_stop)
  );
  assign rxfc_on    = s_r.flow[7:6] != 2'h0;
  assign txfc_on    = s_r.flow[5:4] != 2'h0;
  assign rx_dbl     = s_r.flow[7:6] == `UFSC_DOUBLE;
  assign tx_dbl     = s_r.flow[5:4] == `UFSC_DOUBLE;
  // pause or resume on threshold edge
  assign seq_req    = rxfc_on && (rx_stop != s_r.sw_stop) && !seq_busy;
  assign seq_first  = rx_stop ? s_r.pause_char_first : s_r.resume_char_first;
  assign seq_second = rx_stop ? s_r.pause_char_second : s_r.resume_char_second;
  ufsc_tx_seq u_tx_seq (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst | ~i_rst_n),
    .i_req     (seq_req),
    .i_double  (rx_dbl),
    .i_first   (seq_first),
    .i_second  (seq_second),
    .o_busy    (seq_busy),
    .o_valid   (o_ctl_valid),
    .o_data    (o_ctl_data),
    .i_ready   (i_ctl_ready)
  );
  assign m_resume_char_first  = i_rx_data == s_r.resume_char_first;
  assign m_pause_char_first = i_rx_data == s_r.pause_char_first;
  assign m_resume_char_second  = i_rx_data == s_r.resume_char_second;
  assign m_pause_char_second = i_rx_data == s_r.pause_char_second;
  // double wide needs first then second
  always_comb begin
    is_ctl = 1'b0;
    if (txfc_on && i_rx_valid) begin
      if (!tx_dbl) begin
        is_ctl = m_resume_char_first | m_pause_char_first;
      end else begin
        is_ctl = (s_r.ci == UFSC_CI_FIRST) & (s_r.ci_off ? m_pause_char_second : m_resume_char_second);
        is_ctl = is_ctl | m_resume_char_first | m_pause_char_first;
      end
    end
  end
  assign o_rx_store = i_rx_valid && !is_ctl && s_r.pwr != UFSC_SLEEP;
  assign activity   = (i_cts_n != s_r.cts_q) || (i_rxd != s_r.rxd_q) ||
                      (i_gpi != s_r.gpi_q);
  assign irq_pend   = |(s_r.top_irq_status_reg & s_r.top_irq_enable_reg) || i_other_irq;
  assign hit        = i_hsel && i_htrans[1] && i_hready;
  always_comb begin
    s_nxt = s_r;
    s_nxt.cts_q = i_cts_n;
    s_nxt.rxd_q = i_rxd;
    s_nxt.gpi_q = i_gpi;
    s_nxt.rst_n_q = i_rst_n;
    s_nxt.ph_wr = hit && i_hwrite;
    if (hit) begin
      s_nxt.ph_addr = i_haddr;
    end
    if (seq_req) begin
      s_nxt.sw_stop = rx_stop;
    end
    // Read data and clear on read
    s_nxt.rdata = 32'h0;
    if (hit && !i_hwrite) begin
      unique case (i_haddr[7:0])
        `UFSC_A_ISR: begin
          s_nxt.rdata[7:0] = s_r.top_irq_status_reg;
          s_nxt.top_irq_status_reg = 8'h0;
        end
        `UFSC_A_TOP_IRQ_ENABLE_REG:   s_nxt.rdata[7:0] = s_r.top_irq_enable_reg;
        `UFSC_A_SPCL: begin
          s_nxt.rdata[7:0] = s_r.spcl;
          s_nxt.spcl = 8'h0;
        end
        `UFSC_A_STS: begin
          s_nxt.rdata[7:0] = s_r.sts;
          s_nxt.sts = 8'h0;
        end
        `UFSC_A_FIRST_MODE_REG:   s_nxt.rdata[7:0] = s_r.first_mode_reg;
        `UFSC_A_FLOW_THRESHOLD_REG: s_nxt.rdata[7:0] = s_r.flow_threshold_reg;
        `UFSC_A_TRGLVL:  s_nxt.rdata[7:0] = s_r.trglvl;
        `UFSC_A_TXLVL:   s_nxt.rdata[7:0] = i_tx_level;
        `UFSC_A_RXLVL:   s_nxt.rdata[7:0] = i_rx_level;
        `UFSC_A_FLOW:    s_nxt.rdata[7:0] = s_r.flow;
        `UFSC_A_RESUME_CHAR_FIRST:    s_nxt.rdata[7:0] = s_r.resume_char_first;
        `UFSC_A_RESUME_CHAR_SECOND:    s_nxt.rdata[7:0] = s_r.resume_char_second;
        `UFSC_A_PAUSE_CHAR_FIRST:   s_nxt.rdata[7:0] = s_r.pause_char_first;
        `UFSC_A_PAUSE_CHAR_SECOND:   s_nxt.rdata[7:0] = s_r.pause_char_second;
        default:         s_nxt.rdata = 32'h0;
      endcase
    end
    if (s_r.ph_wr) begin
      unique case (s_r.ph_addr)
        `UFSC_A_TOP_IRQ_ENABLE_REG:   s_nxt.top_irq_enable_reg   = i_hwdata[7:0];
        `UFSC_A_FIRST_MODE_REG:   s_nxt.first_mode_reg   = i_hwdata[7:0];
        `UFSC_A_FLOW_THRESHOLD_REG: s_nxt.flow_threshold_reg = i_hwdata[7:0];
        `UFSC_A_TRGLVL:  s_nxt.trglvl  = i_hwdata[7:0];
        `UFSC_A_FLOW:    s_nxt.flow    = i_hwdata[7:0];
        `UFSC_A_RESUME_CHAR_FIRST:    s_nxt.resume_char_first    = i_hwdata[7:0];
        `UFSC_A_RESUME_CHAR_SECOND:    s_nxt.resume_char_second    = i_hwdata[7:0];
        `UFSC_A_PAUSE_CHAR_FIRST:   s_nxt.pause_char_first   = i_hwdata[7:0];
        `UFSC_A_PAUSE_CHAR_SECOND:   s_nxt.pause_char_second   = i_hwdata[7:0];
        default: s_nxt.flow = s_r.flow;
      endcase
    end
    // clear change flag always set; set beats clear
    if (i_cts_n != s_r.cts_q) begin
      s_nxt.top_irq_status_reg[`UFSC_B_CLEAR_INPUT_CHANGE_FLAG] = 1'b1;
    end
    // trigger flags, levels in units of 8 words
    if (i_rx_level >= {1'b0, s_r.trglvl[7:4], 3'h0} &&
        s_r.trglvl[7:4] != 4'h0) begin
      s_nxt.top_irq_status_reg[`UFSC_B_RXTRG] = 1'b1;
    end
    if (i_tx_level >= {1'b0, s_r.trglvl[3:0], 3'h0} &&
        s_r.trglvl[3:0] != 4'h0) begin
      s_nxt.top_irq_status_reg[`UFSC_B_TXTRG] = 1'b1;
    end
    if (txfc_on && i_rx_valid) begin
      if (tx_dbl) begin
        if (s_r.ci == UFSC_CI_FIRST &&
            (s_r.ci_off ? m_pause_char_second : m_resume_char_second)) begin
          s_nxt.txhalt = s_r.ci_off;
          s_nxt.ci = UFSC_CI_NONE;
          s_nxt.top_irq_status_reg[`UFSC_B_SPINT] = 1'b1;
          if (s_r.ci_off) begin
            s_nxt.spcl[`UFSC_SP_PAUSE_CHAR_SECOND] = 1'b1;
          end else begin
            s_nxt.spcl[`UFSC_SP_RESUME_CHAR_SECOND] = 1'b1;
          end
        end else if (m_resume_char_first || m_pause_char_first) begin
          s_nxt.ci = UFSC_CI_FIRST;
          s_nxt.ci_off = m_pause_char_first;
        end else begin
          s_nxt.ci = UFSC_CI_NONE;
        end
      end else if (m_resume_char_first || m_pause_char_first) begin
        s_nxt.txhalt = m_pause_char_first;
        s_nxt.top_irq_status_reg[`UFSC_B_SPINT] = 1'b1;
        if (m_pause_char_first) begin
          s_nxt.spcl[`UFSC_SP_PAUSE_CHAR_FIRST] = 1'b1;
        end else begin
          s_nxt.spcl[`UFSC_SP_RESUME_CHAR_FIRST] = 1'b1;
        end
      end
    end
    if (!txfc_on) begin
      s_nxt.txhalt = 1'b0;
    end
    if (!i_tx_busy || i_tx_word_done) begin
      s_nxt.gate_q = (s_r.flow[`UFSC_B_TX_GATE_BY_CLEAR_INPUT_ENABLE] && i_cts_n) ||
                     s_nxt.txhalt;
    end
    if (activity || !s_r.first_mode_reg[`UFSC_B_ASLEEP] || irq_pend ||
        i_rx_level != 8'h0 || i_tx_level != 8'h0) begin
      s_nxt.idle = 17'h0;
    end else if (i_char_tick && s_r.idle != IDLE_CHARS) begin
      s_nxt.idle = s_r.idle + 17'h1;
    end
    unique case (s_r.pwr)
      UFSC_RUN: begin
        if (s_r.first_mode_reg[`UFSC_B_FSLEEP] ||
            (s_r.idle == IDLE_CHARS && s_r.first_mode_reg[`UFSC_B_ASLEEP])) begin
          s_nxt.pwr = UFSC_SLEEP;
        end
      end
      UFSC_SLEEP: begin
        // leave on activity or enable cleared
        if (!s_r.first_mode_reg[`UFSC_B_FSLEEP] &&
            (activity || !s_r.first_mode_reg[`UFSC_B_ASLEEP])) begin
          s_nxt.pwr = UFSC_WAKE;
          s_nxt.settle = `UFSC_CLK_SETTLE;
          s_nxt.idle = 17'h0;
        end
      end
      UFSC_WAKE: begin
        if (s_r.settle == 8'h0) begin
          s_nxt.sts[`UFSC_B_CLKRDY] = 1'b1;
          s_nxt.pwr = UFSC_RUN;
        end else begin
          s_nxt.settle = s_r.settle - 8'h1;
        end
      end
      default: s_nxt.pwr = UFSC_RUN;
    endcase
    if (s_r.init != 8'h0) begin
      s_nxt.init = s_r.init - 8'h1;
      if (s_r.init == 8'h1) begin
        s_nxt.sts[`UFSC_B_CLKRDY] = 1'b1;
      end
    end
    // reset pin rising edge restarts initialisation
    if (i_rst_n && !s_r.rst_n_q) begin
      s_nxt.init = `UFSC_INIT_CYC;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !i_rst_n) begin
      s_r <= '0;
      s_r.cts_q <= 1'b1;
      s_r.rxd_q <= 1'b1;
      s_r.init <= `UFSC_INIT_CYC;
    end else begin
      s_r <= s_nxt;
    end
  end
  // gate; host holds transmitter off while enabling
  assign o_tx_allow = !s_r.gate_q && s_r.pwr == UFSC_RUN &&
                      !s_r.first_mode_reg[`UFSC_B_TXOFF];
  assign o_rts_n    = s_r.flow[`UFSC_B_RX_LEVEL_HANDSHAKE_ENABLE] ? rx_stop : 1'b0;
  assign o_sleep    = s_r.pwr == UFSC_SLEEP;
  // low during initialisation, then interrupt level
  assign o_irq_n    = (s_r.init != 8'h0 || !s_r.rst_n_q) ? 1'b0 :
                      !(s_r.first_mode_reg[`UFSC_B_IRQSEL] && irq_pend);
  assign o_hrdata   = s_r.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp    = 1'b0;
  chk_spec_flag: assert property (
    (i_rst_n && txfc_on && i_rx_valid && (tx_dbl ?
     (s_r.ci == UFSC_CI_FIRST && (s_r.ci_off ? m_pause_char_second : m_resume_char_second)) :
     (m_resume_char_first || m_pause_char_first))) |=> (!i_rst_n || s_r.top_irq_status_reg[`UFSC_B_SPINT]))
    else $error("special flag missed");
  chk_ctl_drop: assert property (
    is_ctl |-> !o_rx_store) else $error("control char stored");
  chk_rts_halt: assert property (
    (i_rst_n && s_r.flow[`UFSC_B_RX_LEVEL_HANDSHAKE_ENABLE] && $stable(s_r.flow) &&
     i_rx_level > {1'b0, s_r.flow_threshold_reg[3:0], 3'h0} && $stable(i_rx_level))
    |=> (!i_rst_n || o_rts_n)) else $error("handshake not deasserted");
  chk_tx_gate: assert property (
    (s_r.flow[`UFSC_B_TX_GATE_BY_CLEAR_INPUT_ENABLE] && i_cts_n && !i_tx_busy) |=>
    (!i_rst_n || !o_tx_allow)) else $error("transmit not gated");
  chk_word_done: assert property (
    (i_tx_busy && !i_tx_word_done && i_rst_n) |=>
    (!i_rst_n || $stable(s_r.gate_q))) else $error("gate changed mid word");
  chk_sleep_hold: assert property (
    (i_rst_n && s_r.first_mode_reg[`UFSC_B_FSLEEP] && s_r.pwr == UFSC_RUN) |=>
    (!i_rst_n || o_sleep)) else $error("manual sleep not entered");
  chk_init_irq: assert property (
    $rose(i_rst_n) |=> !o_irq_n [*8]) else $error("irq high early");
  chk_trig_rx: assert property (
    (i_rst_n && s_r.trglvl[7:4] != 4'h0 &&
     i_rx_level >= {1'b0, s_r.trglvl[7:4], 3'h0}) |=>
    (!i_rst_n || s_r.top_irq_status_reg[`UFSC_B_RXTRG])) else $error("rx trigger missed");
  cov_sleep: cover property (@(posedge i_clk_sys) s_r.pwr == UFSC_SLEEP);
  cov_ctl:   cover property (@(posedge i_clk_sys) o_ctl_valid && i_ctl_ready);
  cov_halt:  cover property (@(posedge i_clk_sys) s_r.txhalt);
endmodule

//--- hdl/ufsc_tx_seq.sv
// Control character sender, single or double wide
`timescale 1ns/1ps
module ufsc_tx_seq (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  // Request
  input  wire logic       i_req,
  input  wire logic       i_double,
  input  wire logic [7:0] i_first,
  input  wire logic [7:0] i_second,
  output logic            o_busy,
  // Byte out to the shifter
  output logic            o_valid,
  output logic [7:0]      o_data,
  input  wire logic       i_ready
);
  typedef struct packed {
    logic [1:0] left;
    logic [7:0] data;
    logic [7:0] hold;
  } ufsc_sq_t;
  ufsc_sq_t s_r;
  ufsc_sq_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (s_r.left == 2'h0) begin
      if (i_req) begin
        s_nxt.data = i_first;
        s_nxt.hold = i_second;
        s_nxt.left = i_double ? 2'h2 : 2'h1;
      end
    end else if (i_ready) begin
      s_nxt.left = s_r.left - 2'h1;
      s_nxt.data = s_r.hold;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign o_busy  = s_r.left != 2'h0;
  assign o_valid = s_r.left != 2'h0;
  assign o_data  = s_r.data;
endmodule

//--- testbench/tb_top.sv
// Testbench: bus tasks, scenarios and verdict for flow and sleep control
`timescale 1ns/1ps
module tb_top;
  logic i_clk_sys = 1'b0, i_srst = 1'b1, i_rst_n = 1'b0;
  logic i_hsel = 1'b0, i_hwrite = 1'b0, i_char_tick = 1'b0;
  logic i_tx_word_done = 1'b0, i_tx_busy = 1'b0, i_other_irq = 1'b0;
  logic [7:0] i_haddr = 8'h00, i_rx_level = 8'h00, i_tx_level = 8'h00;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0, o_hrdata, rd;
  logic [3:0] i_gpi = 4'h0;
  logic o_hreadyout, o_hresp, o_rx_store, o_tx_allow, o_ctl_valid;
  logic o_rts_n, o_irq_n, o_sleep, i_ctl_ready, i_rx_valid, i_cts_n, i_rxd;
  logic [7:0] o_ctl_data, i_rx_data;
  logic [7:0] cc [4] = '{8'h11, 8'h91, 8'h13, 8'h93};
  int mismatches = 0, checked = 0, cycles = 0;

  ufsc_top #(.IDLE_CHARS(17'h4)) i_dut (.i_clk_sys, .i_srst, .i_rst_n,
    .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
    .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp,
    .i_rx_level, .i_tx_level, .i_rx_valid, .i_rx_data, .o_rx_store,
    .i_tx_word_done, .i_tx_busy, .o_tx_allow, .o_ctl_valid, .o_ctl_data,
    .i_ctl_ready, .i_char_tick, .i_other_irq, .i_cts_n, .i_rxd, .i_gpi,
    .o_rts_n, .o_irq_n, .o_sleep);
  ufsc_far_end i_far (.i_clk_sys, .i_rts_n(o_rts_n),
    .i_ctl_valid(o_ctl_valid), .i_ctl_data(o_ctl_data),
    .i_rx_store(o_rx_store), .o_ctl_ready(i_ctl_ready),
    .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
    .o_cts_n(i_cts_n), .o_rxd(i_rxd));

  always #2 i_clk_sys = ~i_clk_sys;
  // A hang ends the run as a failure
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    i_hsel <= 1'b1;
    i_hsize <= 3'h2;
    i_haddr <= a;
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= 32'(d);
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask
  task automatic await(ref logic s, input logic v);
    for (int n = 0; n < 300 && s !== v; n++) @(posedge i_clk_sys);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      i_char_tick <= 1'b1;
      @(posedge i_clk_sys);
      i_char_tick <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask
  task automatic pair(input logic [7:0] a, b);
    for (int n = 0; n < 300 && i_far.got_q.size() < 2; n++)
      @(posedge i_clk_sys);
    chk("ctl first", 32'(a), 32'(i_far.got_q[0]));
    chk("ctl second", 32'(b), 32'(i_far.got_q[1]));
    i_far.got_q.delete();
  endtask
  task automatic t_init;
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    chk("irq_n init", 32'h0, 32'(o_irq_n));
    await(o_irq_n, 1'b1);
    chk("irq_n ready", 32'h1, 32'(o_irq_n));
    bus(1, 8'h50, 'h5a);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    chk("irq_n shutdown", 32'h0, 32'(o_irq_n));
    i_rst_n <= 1'b1;
    await(o_irq_n, 1'b1);
    bus(0, 8'h50, 0);
    chk("char reg lost", 32'h0, rd);
    bus(1, 8'h24, 'h80);
    $display("test init done");
  endtask
  task automatic t_hw;
    bus(1, 8'h24, 'h82);
    bus(1, 8'h3c, 'h12);
    bus(1, 8'h04, 'h82);
    bus(1, 8'h4c, 'h02);
    bus(1, 8'h24, 'h80);
    i_rx_level <= 8'd20;
    i_far.cts(1'b0);
    repeat (4) @(posedge i_clk_sys);
    chk("rts_n gating only", 32'h0, 32'(o_rts_n));
    chk("allow cts low", 32'h1, 32'(o_tx_allow));
    bus(0, 8'h08, 0);
    i_far.cts(1'b1);
    await(o_tx_allow, 1'b0);
    chk("allow cts high", 32'h0, 32'(o_tx_allow));
    await(o_irq_n, 1'b0);
    chk("irq_n cts", 32'h0, 32'(o_irq_n));
    bus(0, 8'h08, 0);
    chk("cts flag", 32'h80, rd & 32'h80);
    bus(1, 8'h04, 'h02);
    i_rx_level <= 8'd0;
    i_far.cts(1'b0);
    repeat (4) @(posedge i_clk_sys);
    chk("irq_n masked", 32'h1, 32'(o_irq_n));
    bus(0, 8'h08, 0);
    chk("cts flag masked", 32'h80, rd & 32'h80);
    bus(1, 8'h4c, 'h01);
    i_far.cts(1'b1);
    i_rx_level <= 8'd16;
    repeat (6) @(posedge i_clk_sys);
    chk("rts_n at halt", 32'h0, 32'(o_rts_n));
    chk("allow no gating", 32'h1, 32'(o_tx_allow));
    i_rx_level <= 8'd17;
    await(o_rts_n, 1'b1);
    chk("rts_n above halt", 32'h1, 32'(o_rts_n));
    i_rx_level <= 8'd8;
    repeat (6) @(posedge i_clk_sys);
    chk("rts_n at resume", 32'h1, 32'(o_rts_n));
    i_rx_level <= 8'd7;
    await(o_rts_n, 1'b0);
    chk("rts_n below resume", 32'h0, 32'(o_rts_n));
    chk("irq_n thresholds", 32'h1, 32'(o_irq_n));
    bus(1, 8'h4c, 'h00);
    $display("test hardware flow done");
  endtask
  task automatic t_word;
    bus(1, 8'h24, 'h82);
    bus(1, 8'h4c, 'h02);
    i_far.cts(1'b0);
    bus(1, 8'h24, 'h80);
    i_tx_busy <= 1'b1;
    i_far.cts(1'b1);
    repeat (4) @(posedge i_clk_sys);
    chk("allow mid word", 32'h1, 32'(o_tx_allow));
    i_tx_word_done <= 1'b1;
    i_tx_busy <= 1'b0;
    @(posedge i_clk_sys);
    i_tx_word_done <= 1'b0;
    await(o_tx_allow, 1'b0);
    chk("allow after word", 32'h0, 32'(o_tx_allow));
    bus(1, 8'h4c, 'h00);
    $display("test word end done");
  endtask
  task automatic t_swrx;
    bus(1, 8'h24, 'h82);
    for (int i = 0; i < 4; i++) bus(1, 8'h50 + 8'(4 * i), int'(cc[i]));
    for (int i = 0; i < 4; i++) begin
      bus(0, 8'h50 + 8'(4 * i), 0);
      chk("ctl char reg", 32'(cc[i]), rd);
    end
    bus(1, 8'h4c, 'hc0);
    bus(1, 8'h24, 'h80);
    i_far.stall <= 1'b1;
    i_rx_level <= 8'd17;
    pair(8'h13, 8'h93);
    i_rx_level <= 8'd7;
    pair(8'h11, 8'h91);
    i_far.stall <= 1'b0;
    bus(1, 8'h4c, 'h00);
    $display("test receive flow done");
  endtask
  task automatic t_swtx;
    bus(1, 8'h24, 'h82);
    bus(1, 8'h4c, 'h30);
    bus(1, 8'h24, 'h80);
    bus(0, 8'h08, 0);
    i_far.send(8'h13);
    i_far.send(8'h93);
    chk("pause stored", 32'h0, 32'(i_far.stored));
    await(o_tx_allow, 1'b0);
    chk("allow paused", 32'h0, 32'(o_tx_allow));
    bus(0, 8'h08, 0);
    chk("special flag", 32'h2, rd & 32'h2);
    bus(0, 8'h18, 0);
    chk("detail pause", 32'h1, 32'(|rd[3:2]));
    i_far.send(8'h41);
    chk("data stored", 32'h1, 32'(i_far.stored));
    i_far.send(8'h11);
    i_far.send(8'h91);
    chk("resume stored", 32'h0, 32'(i_far.stored));
    await(o_tx_allow, 1'b1);
    chk("allow resumed", 32'h1, 32'(o_tx_allow));
    i_far.send(8'h93);
    repeat (4) @(posedge i_clk_sys);
    chk("lone second byte", 32'h1, 32'(i_far.stored));
    chk("allow lone byte", 32'h1, 32'(o_tx_allow));
    bus(1, 8'h4c, 'h00);
    $display("test transmit flow done");
  endtask
  task automatic t_trig;
    i_rx_level <= 8'd7;
    i_tx_level <= 8'd15;
    bus(1, 8'h40, 'h12);
    bus(0, 8'h08, 0);
    bus(0, 8'h08, 0);
    chk("trigger below", 32'h0, rd & 32'h18);
    i_rx_level <= 8'd8;
    i_tx_level <= 8'd16;
    repeat (3) @(posedge i_clk_sys);
    bus(0, 8'h08, 0);
    chk("trigger reached", 32'h18, rd & 32'h18);
    i_rx_level <= 8'd0;
    i_tx_level <= 8'd0;
    $display("test trigger done");
  endtask
  task automatic t_sleep;
    bus(0, 8'h20, 0);
    bus(1, 8'h24, 'ha0);
    await(o_sleep, 1'b1);
    chk("manual sleep", 32'h1, 32'(o_sleep));
    bus(0, 8'h3c, 0);
    chk("reg in sleep", 32'h12, rd);
    bus(1, 8'h24, 'h80);
    await(o_sleep, 1'b0);
    chk("sleep exit", 32'h0, 32'(o_sleep));
    bus(0, 8'h20, 0);
    chk("clocks settling", 32'h0, rd & 32'h20);
    repeat (80) @(posedge i_clk_sys);
    bus(0, 8'h20, 0);
    chk("clocks stable", 32'h20, rd & 32'h20);
    bus(1, 8'h04, 'h00);
    bus(0, 8'h08, 0);
    bus(1, 8'h24, 'hc0);
    i_other_irq <= 1'b1;
    tick(6);
    chk("awake irq pending", 32'h0, 32'(o_sleep));
    i_other_irq <= 1'b0;
    tick(3);
    chk("awake early", 32'h0, 32'(o_sleep));
    tick(3);
    await(o_sleep, 1'b1);
    chk("idle sleep", 32'h1, 32'(o_sleep));
    i_gpi <= 4'h1;
    await(o_sleep, 1'b0);
    chk("pin wake", 32'h0, 32'(o_sleep));
    tick(6);
    await(o_sleep, 1'b1);
    bus(1, 8'h24, 'h80);
    await(o_sleep, 1'b0);
    chk("enable cleared", 32'h0, 32'(o_sleep));
    $display("test sleep done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    t_init;
    t_hw;
    t_word;
    t_swrx;
    t_swtx;
    t_trig;
    t_sleep;
    tally_and_finish;
  end
endmodule

//--- testbench/ufsc_far_end.sv
// Far-end UART model: sends words, collects control bytes, drives clear pin
`timescale 1ns/1ps
module ufsc_far_end (
  // Clock
  input  wire logic       i_clk_sys,
  // From the block
  input  wire logic       i_rts_n,
  input  wire logic       i_ctl_valid,
  input  wire logic [7:0] i_ctl_data,
  input  wire logic       i_rx_store,
  // To the block
  output logic            o_ctl_ready = 1'b0,
  output logic            o_rx_valid = 1'b0,
  output logic [7:0]      o_rx_data = 8'h00,
  output logic            o_cts_n = 1'b1,
  output logic            o_rxd = 1'b1
);
  logic [7:0] got_q[$];
  logic       stall = 1'b0;
  logic       stored = 1'b0;
  // Slow mode accepts a control byte only every other cycle
  always @(posedge i_clk_sys) begin
    if (i_ctl_valid && o_ctl_ready)
      got_q.push_back(i_ctl_data);
    if (o_rx_valid)
      stored <= i_rx_store;
    o_ctl_ready <= stall ? ~o_ctl_ready : 1'b1;
  end
  task automatic cts(input logic v);
    o_cts_n <= v;
  endtask
  // no new word while handshake is deasserted
  task automatic send(input logic [7:0] b);
    while (i_rts_n !== 1'b0)
      @(posedge i_clk_sys);
    o_rx_data <= b;
    o_rx_valid <= 1'b1;
    o_rxd <= 1'b0;
    @(posedge i_clk_sys);
    // Released data shows the inverse, never a stale copy
    o_rx_valid <= 1'b0;
    o_rx_data <= ~b;
    o_rxd <= 1'b1;
    @(posedge i_clk_sys);
  endtask
endmodule
